// [tss_sense_status.sv]
// Purpose: sense bytes 0-4 of a tape control unit, bytes 0-3 and byte 4 bit 6 read over avalon-mm
// Assumes: channel and drive inputs synchronous to sys_clk
// Notes:   sense bytes clear when a new command is accepted
// Notes on behaviour
// - reject write-type command without write permission
// - reject unknown command codes
// - secure erase only right after erase gap
// - reject reserve/release unless option and first
// - intervention required when drive absent or unready
// - ready lost mid-command forces unit check
// - even bus-out parity sets bus-out check
// - equipment check from reject, drive check busy
// - data check from noise or check bits
// - phase-encoded empty block: data check plus noise
// - data check from byte4 bit3, mode bit4
// - late service sets overrun, stops transfer
// - data check suppresses overrun
// - word count zero on empty write, halt
// - flag padded last byte on forward read
// - noise on empty read or stop-delay data
// - status bits A/B give selection response
// - not-capable on unsupported format or tracks
// - track byte updated at end, seven-track read 03
// - vertical parity check on read, pe write
// - envelope bit on nrzi write, pe write
// - reject-drive on ready drop or status change
`timescale 1ns/10ps
`default_nettype none
`include "tss_defs.svh"
module tss_sense_status #(
   parameter int unsigned TRACKS = 9   // tracks per drive
) (
   input  wire logic                   sys_clk,
   input  wire logic                   sys_rst,
   input  wire logic [3:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   cmd_valid,
   input  wire logic [7:0]             cmd_code,
   input  wire logic                   cmd_chained,
   input  wire logic                   cmd_first,
   input  wire logic                   prev_erase_gap,
   input  wire logic                   dual_switch_present,
   input  wire logic                   extended_mode,
   input  wire logic                   phase_encoded_format,
   input  wire logic                   data_converted,
   input  wire tss_pkg::tss_drive_s    tape_drive,
   input  wire tss_pkg::tss_event_s    evt,
   input  wire logic [7:0]             track_errs,
   output logic                        cmd_rejected,
   output logic                        unit_check,
   output logic                        device_end,
   output logic                        xfer_stop
);
   import tss_pkg::*;
   // only 7- and 9-track formats are decoded
   if (TRACKS != 7 && TRACKS != 9) begin : g_bad_trk
      $error("TRACKS must be 7 or 9");
   end
   // one clock domain for every check below
   default clocking cb_sys @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // sense bytes
   logic [7:0] s0_q, s1_q, s2_q, s3_q, s4_q;
   logic [7:0] s0_d, s1_d, s2_d, s3_d, s4_d;
   tss_op_e    op_q, op_d;       // running operation class
   logic       ovr_raw_q;        // overrun seen, before suppression
   logic       de_arm_q;         // device end armed
   logic       ready_was_q;      // ready during command
   logic       rdack_q;          // bus read answer cycle
   logic       stop_q;           // transfer stop, one-cycle pulse after overrun
   logic       uc_q;
   // write-type command decode, used twice
   function automatic logic is_write_type(input logic [7:0] c);
      return c == `TSS_CMD_WRITE || c == `TSS_CMD_WTM ||
             c == `TSS_CMD_ERASE || c == `TSS_CMD_LWR ||
             c == `TSS_CMD_SEC_ERA;
   endfunction
   function automatic logic is_known(input logic [7:0] c);
      return is_write_type(c) || c == `TSS_CMD_READ ||
             c == `TSS_CMD_RDBK || c == `TSS_CMD_SENSE ||
             c == `TSS_CMD_RESERVE || c == `TSS_CMD_RELEASE ||
             c == `TSS_CMD_NOP;
   endfunction
   // command checks
   wire w_is_wr   = is_write_type(cmd_code);
   wire rej_prot  = cmd_valid && w_is_wr && !tape_drive.write_ok;
   wire rej_unk   = cmd_valid && !is_known(cmd_code);
   wire rej_sec   = cmd_valid && cmd_code == `TSS_CMD_SEC_ERA &&
                    !(cmd_chained && prev_erase_gap);
   wire is_rsv    = cmd_code == `TSS_CMD_RESERVE ||
                    cmd_code == `TSS_CMD_RELEASE;
   wire rej_rsv   = cmd_valid && is_rsv &&
                    (!dual_switch_present || !cmd_first);
   wire reject    = rej_prot || rej_unk || rej_sec || rej_rsv;
   wire not_ready = !tape_drive.exists || !tape_drive.ready;
   wire accept    = cmd_valid && !reject && !not_ready;
   // drive status bits
   wire st_a = tape_drive.exists && tape_drive.ready &&
               !tape_drive.busy && !tape_drive.rewinding;
   wire st_b = tape_drive.exists &&
               (!tape_drive.ready || tape_drive.rewinding);
   wire in_op   = op_q != TSS_OP_IDLE;
   wire rw_op   = op_q == TSS_OP_READ || op_q == TSS_OP_RDBK ||
                  op_q == TSS_OP_WRITE;
   wire rd_op   = op_q == TSS_OP_READ || op_q == TSS_OP_RDBK;
   wire ready_drop = in_op && ready_was_q && !tape_drive.ready;
   // byte 4: reject drive
   wire rej_drv = ready_drop || (in_op && tape_drive.rd_stat_chg);
   // byte 1 noise
   wire noise_ev = (rd_op && evt.no_data) ||
                   (rd_op && evt.stop_dly_dat) ||
                   (rd_op && phase_encoded_format &&
                    evt.eob_no_data);
   // byte 3 checks, and byte 1 not-capable
   wire vpc_ev = (rd_op && evt.vpc_err) ||
                 (op_q == TSS_OP_WRITE && phase_encoded_format &&
                  evt.vpc_err && !evt.env_err);
   wire env_ev = op_q != TSS_OP_IDLE && !rd_op && evt.env_err;
   wire fmt_ev = rw_op && (evt.fmt_bad ||
                 (tape_drive.seven_track && TRACKS != 7));
   // data check and other byte 0 sources
   wire b3_any  = (s3_d & 8'hf9) != 8'h00;
   wire dchk_ev = s1_d[`TSS_B1_NOISE] || (rw_op && b3_any) ||
                  s4_d[4] ||
                  (extended_mode ? evt.b5_bit4 : s4_d[3]);
   wire eq_ev   = s4_d[`TSS_B4_REJ_DRV] ||
                  (in_op && tape_drive.drv_check);
   wire ovr_ev  = rw_op && evt.svc_late;
   wire wcz_ev  = (op_q == TSS_OP_WRITE && evt.first_cmdout) ||
                  (op_q == TSS_OP_WRITE && evt.halt_io);
   wire dcc_ev  = op_q == TSS_OP_READ && data_converted &&
                  evt.pad_last;
   // next sense values; events set over a new-command clear
   always_comb begin
      s1_d = accept ? 8'h00 : s1_q;
      s1_d[`TSS_B1_STAT_A] = st_a;
      s1_d[`TSS_B1_STAT_B] = st_b;
      if (noise_ev) s1_d[`TSS_B1_NOISE] = 1'b1;
      if (fmt_ev) s1_d[`TSS_B1_NOT_CAP] = 1'b1;
      s3_d = accept ? 8'h00 : s3_q;
      if (vpc_ev) s3_d[`TSS_B3_VPC] = 1'b1;
      if (env_ev) s3_d[`TSS_B3_ENV] = 1'b1;
      if (rw_op && evt.chk_err) s3_d[6] = 1'b1;
      s4_d = accept ? 8'h00 : s4_q;
      if (rej_drv) s4_d[`TSS_B4_REJ_DRV] = 1'b1;
      if (evt.b4_bit3) s4_d[4] = 1'b1;
      if (evt.b4_bit4 && !extended_mode) s4_d[3] = 1'b1;
      // track byte updated at command end
      s2_d = (cmd_valid && !reject) ? 8'h00 : s2_q;
      if (in_op && evt.op_end) begin
         s2_d = (tape_drive.seven_track && rd_op) ?
                `TSS_TIE_7TRK : track_errs;
      end
      s0_d = cmd_valid ? 8'h00 : s0_q;
      if (reject) s0_d[`TSS_B0_CMD_REJ] = 1'b1;
      if (cmd_valid && not_ready) s0_d[`TSS_B0_INT_REQ] = 1'b1;
      if (evt.parity_even) s0_d[`TSS_B0_BUS_OUT] = 1'b1;
      if (eq_ev) s0_d[`TSS_B0_EQ_CHK] = 1'b1;
      if (dchk_ev) s0_d[`TSS_B0_DATA_CHK] = 1'b1;
      // a held overrun must not leak into the next command's byte
      if (ovr_ev || (ovr_raw_q && !cmd_valid))
         s0_d[`TSS_B0_OVERRUN] = 1'b1;
      if (s0_d[`TSS_B0_DATA_CHK]) s0_d[`TSS_B0_OVERRUN] = 1'b0;
      if (wcz_ev) s0_d[`TSS_B0_WCZ] = 1'b1;
      if (dcc_ev) s0_d[`TSS_B0_DCC] = 1'b1;
   end
   // operation class from accepted command
   always_comb begin
      op_d = op_q;
      if (accept) begin
         case (cmd_code)
            `TSS_CMD_READ:  op_d = TSS_OP_READ;
            `TSS_CMD_RDBK:  op_d = TSS_OP_RDBK;
            `TSS_CMD_WRITE: op_d = TSS_OP_WRITE;
            `TSS_CMD_LWR:   op_d = TSS_OP_WRITE;
            default:        op_d = TSS_OP_OTHER;
         endcase
      end else if (evt.op_end || ready_drop || stop_q) begin
         op_d = TSS_OP_IDLE;
      end
   end
   // state registers, kept short
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s0_q <= 8'h00;
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
         s4_q <= 8'h00;
         op_q <= TSS_OP_IDLE;
         ovr_raw_q <= 1'b0;
         de_arm_q <= 1'b0;
         ready_was_q <= 1'b0;
         stop_q <= 1'b0;
         uc_q <= 1'b0;
      end else begin
         s0_q <= s0_d;
         s1_q <= s1_d;
         s2_q <= s2_d;
         s3_q <= s3_d;
         s4_q <= s4_d;
         op_q <= op_d;
         ovr_raw_q <= (ovr_raw_q && !cmd_valid) || ovr_ev;
         ready_was_q <= accept ? 1'b1 : (in_op && tape_drive.ready);
         stop_q <= ovr_ev;
         // unit check on not ready, reject or ready lost
         uc_q <= (cmd_valid && (reject || not_ready)) || ready_drop;
         // device end armed when selected unready, fires once ready
         if (cmd_valid && st_b) de_arm_q <= 1'b1;
         else if (st_a) de_arm_q <= 1'b0;
      end
   end
   // avalon slave: one wait cycle on reads, writes ignored
   always_ff @(posedge sys_clk) begin
      if (sys_rst) rdack_q <= 1'b0;
      else rdack_q <= avs_read && !rdack_q;
   end
   wire [7:0] rd_sel = (avs_address == `TSS_OFF_SENSE0) ? s0_q :
                       (avs_address == `TSS_OFF_SENSE1) ? s1_q :
                       (avs_address == `TSS_OFF_SENSE2) ? s2_q :
                       (avs_address == `TSS_OFF_SENSE3) ? s3_q : 8'h00;
   wire [7:0] rd_s4 = {1'b0, s4_q[6], 6'h00};
   logic [31:0] rdata_q;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) rdata_q <= 32'h0;
      else rdata_q <= {16'h0, rd_s4, rd_sel};
   end
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = avs_read && !rdack_q;
   assign cmd_rejected    = s0_q[`TSS_B0_CMD_REJ];
   assign unit_check      = uc_q;
   assign device_end      = de_arm_q && st_a;
   assign xfer_stop       = stop_q;
   // assertions
   property p_reject_unknown;
      @(posedge sys_clk) disable iff (sys_rst)
      rej_unk |=> s0_q[`TSS_B0_CMD_REJ];
   endproperty
   a_reject_unknown: assert property (p_reject_unknown)
      else $error("unknown command not rejected");
   property p_protect;
      @(posedge sys_clk) disable iff (sys_rst)
      (cmd_valid && w_is_wr && !tape_drive.write_ok) |=> cmd_rejected;
   endproperty
   a_protect: assert property (p_protect)
      else $error("write to protected drive not rejected");
   property p_intreq;
      @(posedge sys_clk) disable iff (sys_rst)
      (cmd_valid && !tape_drive.exists) |=> s0_q[6] && unit_check;
   endproperty
   a_intreq: assert property (p_intreq)
      else $error("intervention required missing");
   property p_busout;
      @(posedge sys_clk) disable iff (sys_rst)
      evt.parity_even |=> s0_q[`TSS_B0_BUS_OUT];
   endproperty
   a_busout: assert property (p_busout)
      else $error("bus-out check missing");
   property p_suppress;
      @(posedge sys_clk) disable iff (sys_rst)
      s0_q[`TSS_B0_DATA_CHK] |-> !s0_q[`TSS_B0_OVERRUN];
   endproperty
   a_suppress: assert property (p_suppress)
      else $error("overrun shown with data check");
   sequence s_late;
      rw_op && evt.svc_late;
   endsequence
   property p_overrun_stop;
      @(posedge sys_clk) disable iff (sys_rst)
      s_late |=> xfer_stop ##1 (op_q == TSS_OP_IDLE || accept);
   endproperty
   a_overrun_stop: assert property (p_overrun_stop)
      else $error("transfer not stopped on overrun");
   property p_tie7;
      @(posedge sys_clk) disable iff (sys_rst)
      (rd_op && evt.op_end && tape_drive.seven_track) |=>
         s2_q == `TSS_TIE_7TRK;
   endproperty
   a_tie7: assert property (p_tie7)
      else $error("seven-track pattern wrong");
   property p_equip;
      @(posedge sys_clk) disable iff (sys_rst)
      $rose(s4_q[`TSS_B4_REJ_DRV]) |-> s0_q[`TSS_B0_EQ_CHK];
   endproperty
   a_equip: assert property (p_equip)
      else $error("equipment check missing");
   property p_status_ab;
      @(posedge sys_clk) disable iff (sys_rst)
      !tape_drive.exists |=> !s1_q[6] && !s1_q[5];
   endproperty
   a_status_ab: assert property (p_status_ab)
      else $error("status bits wrong for absent drive");

   property p_sec_erase;
      rej_sec |=> cmd_rejected && unit_check;
   endproperty
   a_sec_erase: assert property (p_sec_erase)
      else $error("secure erase not rejected");

   property p_rsv_rej;
      rej_rsv |=> cmd_rejected && unit_check;
   endproperty
   a_rsv_rej: assert property (p_rsv_rej)
      else $error("reserve not rejected");

   property p_drop_uc;
      ready_drop |=> unit_check;
   endproperty
   a_drop_uc: assert property (p_drop_uc)
      else $error("no unit check on drop");

   property p_chk_dchk;
      (rw_op && evt.chk_err) |=> s0_q[`TSS_B0_DATA_CHK];
   endproperty
   a_chk_dchk: assert property (p_chk_dchk)
      else $error("check bit without data check");

   property p_pe_empty;
      (rd_op && phase_encoded_format && evt.eob_no_data) |=>
         s0_q[`TSS_B0_DATA_CHK] && s1_q[`TSS_B1_NOISE];
   endproperty
   a_pe_empty: assert property (p_pe_empty)
      else $error("empty block not flagged");

   property p_b4_dchk;
      evt.b4_bit3 |=> s0_q[`TSS_B0_DATA_CHK];
   endproperty
   a_b4_dchk: assert property (p_b4_dchk)
      else $error("byte 4 check without data check");

   property p_wcz_halt;
      (op_q == TSS_OP_WRITE && evt.halt_io) |=> s0_q[`TSS_B0_WCZ];
   endproperty
   a_wcz_halt: assert property (p_wcz_halt)
      else $error("halt gave no word count zero");

   property p_pad_flag;
      (op_q == TSS_OP_READ && data_converted && evt.pad_last) |=>
         s0_q[`TSS_B0_DCC];
   endproperty
   a_pad_flag: assert property (p_pad_flag)
      else $error("padded byte not flagged");

   property p_noise;
      (rd_op && evt.no_data) |=> s1_q[`TSS_B1_NOISE];
   endproperty
   a_noise: assert property (p_noise)
      else $error("noise bit missing");

   property p_not_cap;
      (rw_op && evt.fmt_bad) |=> s1_q[`TSS_B1_NOT_CAP];
   endproperty
   a_not_cap: assert property (p_not_cap)
      else $error("not-capable bit missing");

   property p_vpc_read;
      (rd_op && evt.vpc_err) |=> s3_q[`TSS_B3_VPC];
   endproperty
   a_vpc_read: assert property (p_vpc_read)
      else $error("vertical parity bit missing");

   property p_env_write;
      (op_q == TSS_OP_WRITE && evt.env_err) |=> s3_q[`TSS_B3_ENV];
   endproperty
   a_env_write: assert property (p_env_write)
      else $error("envelope bit missing");

   property p_rej_drive;
      ready_drop |=> s4_q[`TSS_B4_REJ_DRV];
   endproperty
   a_rej_drive: assert property (p_rej_drive)
      else $error("reject drive bit missing");
endmodule
`default_nettype wire

// [tss_defs.svh]
// Purpose: offsets, field positions and command codes for the sense-status block
// Assumes: included by tss_sense_status and tb
// Notes:   byte addresses on a 32-bit avalon word bus
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
// register byte addresses
`define TSS_OFF_SENSE0   4'h0
`define TSS_OFF_SENSE1   4'h4
`define TSS_OFF_SENSE2   4'h8
`define TSS_OFF_SENSE3   4'hc
`define TSS_ADDR_W       4
// sense byte 0 bits (bit 0 is the msb of the byte, as on the channel)
`define TSS_B0_CMD_REJ   7
`define TSS_B0_INT_REQ   6
`define TSS_B0_BUS_OUT   5
`define TSS_B0_EQ_CHK    4
`define TSS_B0_DATA_CHK  3
`define TSS_B0_OVERRUN   2
`define TSS_B0_WCZ       1
`define TSS_B0_DCC       0
// sense byte 1 bits
`define TSS_B1_NOISE     7
`define TSS_B1_STAT_A    6
`define TSS_B1_STAT_B    5
`define TSS_B1_NOT_CAP   0
// sense byte 3 bits
`define TSS_B3_VPC       7
`define TSS_B3_ENV       3
// sense byte 4 bits
`define TSS_B4_REJ_DRV   6
// fixed seven-track track_fault_indicator pattern
`define TSS_TIE_7TRK     8'h03
// command codes, low bits chosen locally
`define TSS_CMD_WRITE    8'h01
`define TSS_CMD_READ     8'h02
`define TSS_CMD_RDBK     8'h0c
`define TSS_CMD_SENSE    8'h04
`define TSS_CMD_WTM      8'h1f
`define TSS_CMD_ERASE    8'h17
`define TSS_CMD_LWR      8'h8b
`define TSS_CMD_SEC_ERA  8'h97
`define TSS_CMD_RESERVE  8'hf4
`define TSS_CMD_RELEASE  8'hd4
`define TSS_CMD_NOP      8'h03
`endif

// [tss_pkg.sv]
// Purpose: types shared by the sense-status block
// Assumes: tss_defs.svh gives the numbers
// Notes:   structs carry drive and data-path event groups
package tss_pkg;
   // selected drive state
   typedef struct packed {
      logic exists;       // drive present
      logic ready;        // drive ready
      logic busy;         // drive busy
      logic rewinding;    // rewinding or held by other control
      logic write_ok;     // write ring fitted
      logic seven_track;  // seven-track drive
      logic drv_check;    // drive check line
      logic rd_stat_chg;  // read status changed
   } tss_drive_s;
   // data-path events, one-cycle pulses
   typedef struct packed {
      logic parity_even;  // bus-out byte had even parity
      logic svc_late;     // transfer service missed
      logic eob_no_data;  // end of block before any byte
      logic no_data;      // no data on 800/1600 read
      logic stop_dly_dat; // data in nrzi stop delay
      logic vpc_err;      // uncorrectable vertical parity
      logic env_err;      // envelope low / aux reg parity
      logic chk_err;      // other byte-3 check bit 1,2,3
      logic first_cmdout; // first service in answered by cmd out
      logic halt_io;      // halt i/o received
      logic pad_last;     // last converted byte was padded
      logic fmt_bad;      // unsupported format / no id burst
      logic b4_bit3;      // sense byte 4 bit 3 condition
      logic b4_bit4;      // legacy byte 4 bit 4 condition
      logic b5_bit4;      // extended byte 5 bit 4 condition
      logic op_end;       // command ended
   } tss_event_s;
   // operation class
   typedef enum logic [2:0] {
      TSS_OP_IDLE, TSS_OP_READ, TSS_OP_RDBK, TSS_OP_WRITE, TSS_OP_OTHER
   } tss_op_e;
endpackage

// [tss_drive_model.sv]
// Purpose: behavioural tape drive and data path facing the sense block
// Assumes: the bench calls set_drive and fire from its own process
// Notes:   every change lands on a clock edge, after 0 or more cycles
`timescale 1ns/10ps
`default_nettype none
module tss_drive_model
   import tss_pkg::*;
(
   input  wire logic          sys_clk,
   output var tss_pkg::tss_drive_s tape_drive,
   output var tss_pkg::tss_event_s evt
);
   // start with no drive attached and a quiet data path
   initial begin
      tape_drive = '0;
      evt = '0;
   end
   // drive state changes after dly cycles, so slow drives are covered
   task automatic set_drive(input tss_drive_s d, input int dly);
      repeat (dly) @(posedge sys_clk);
      tape_drive <= d;
   endtask
   // data-path events are one-cycle pulses, never left standing
   task automatic fire(input tss_event_s e, input int dly);
      repeat (dly) @(posedge sys_clk);
      evt <= e;
      @(posedge sys_clk);
      evt <= '0;
   endtask
endmodule
`default_nettype wire

// [tb.sv]
// Purpose: self-checking bench for the sense-status block
// Assumes: avalon reads answer within a few cycles
// Notes:   read expectations are queued as notes and matched by a monitor
`timescale 1ns/10ps
`default_nettype none
`include "tss_defs.svh"
module tb;
   import tss_pkg::*;
   // one case: command, mode bits, event, sense byte and bits seen
   typedef struct packed {
      logic [7:0]  code;  // command
      logic [2:0]  md;    // pe, converted, extended
      logic [15:0] ev;    // event pulse
      logic [3:0]  a;     // sense byte address
      logic [7:0]  m;     // bits looked at
      logic [7:0]  v;     // expected bits
   } tss_case_s;
   localparam logic [7:0] rdc = `TSS_CMD_READ;
   localparam logic [7:0] wrc = `TSS_CMD_WRITE;
   localparam logic [7:0] rbc = `TSS_CMD_RDBK;
   localparam tss_drive_s drv_rw = 8'hc8;   // ready, ring fitted
   localparam tss_drive_s drv_ro = 8'hc0;   // ready, no ring
   localparam tss_drive_s drv_nr = 8'h80;   // present, not ready
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic [3:0]  avs_address = 4'h0;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        cmd_valid = 1'b0;
   logic [7:0]  cmd_code = 8'h0;
   logic [3:0]  fl = 4'h0;           // chained, first, gap, dual switch
   logic [2:0]  md = 3'h0;           // pe, converted, extended
   logic [7:0]  track_errs = 8'h0;
   logic [7:0]  uc, te;              // random command and track byte
   tss_drive_s  tape_drive;
   tss_event_s  evt;
   logic        cmd_rejected, unit_check, device_end, xfer_stop;
   int          fails = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   int          seed = 34465;
   logic [31:0] mq[$], vq[$];        // expectation notes
   string       wq[$];
   logic [3:0]  addr_t [5] = '{4'h0, 4'h4, 4'h8, 4'hc, 4'h2};
   logic [7:0]  wcmd_t [4] = '{wrc, `TSS_CMD_WTM, `TSS_CMD_ERASE,
                               `TSS_CMD_LWR};
   logic [3:0]  fl_t [3] = '{4'b0100, 4'b0001, 4'b0101};
   tss_drive_s  st_t [3] = '{8'h00, drv_nr, drv_rw};
   tss_case_s   tbl [21] = '{
      '{rdc, 3'h0, 16'h8000, 4'h0, 8'h20, 8'h20},
      '{rdc, 3'h0, 16'h1000, 4'h0, 8'h08, 8'h08},
      '{rdc, 3'h0, 16'h1000, 4'h4, 8'h80, 8'h80},
      '{rdc, 3'h0, 16'h0800, 4'h4, 8'h80, 8'h80},
      '{rdc, 3'h4, 16'h2000, 4'h0, 8'h08, 8'h08},
      '{rdc, 3'h4, 16'h2000, 4'h4, 8'h80, 8'h80},
      '{rdc, 3'h0, 16'h4000, 4'h0, 8'h0c, 8'h04},
      '{rdc, 3'h0, 16'h4400, 4'h0, 8'h0c, 8'h08},
      '{rbc, 3'h0, 16'h0400, 4'hc, 8'h80, 8'h80},
      '{wrc, 3'h0, 16'h0200, 4'hc, 8'h08, 8'h08},
      '{wrc, 3'h0, 16'h0100, 4'h0, 8'h08, 8'h08},
      '{wrc, 3'h0, 16'h0080, 4'h0, 8'h02, 8'h02},
      '{wrc, 3'h0, 16'h0040, 4'h0, 8'h02, 8'h02},
      '{rdc, 3'h2, 16'h0020, 4'h0, 8'h01, 8'h01},
      '{rbc, 3'h2, 16'h0020, 4'h0, 8'h01, 8'h00},
      '{rdc, 3'h0, 16'h0010, 4'h4, 8'h01, 8'h01},
      '{rdc, 3'h0, 16'h0008, 4'h0, 8'h08, 8'h08},
      '{rdc, 3'h0, 16'h0004, 4'h0, 8'h08, 8'h08},
      '{rdc, 3'h1, 16'h0004, 4'h0, 8'h08, 8'h00},
      '{rdc, 3'h1, 16'h0002, 4'h0, 8'h08, 8'h08},
      '{rdc, 3'h0, 16'h0002, 4'h0, 8'h08, 8'h00}};

   tss_sense_status uut (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_chained(fl[3]), .cmd_first(fl[2]),
      .prev_erase_gap(fl[1]), .dual_switch_present(fl[0]),
      .extended_mode(md[0]), .phase_encoded_format(md[2]),
      .data_converted(md[1]), .tape_drive(tape_drive), .evt(evt),
      .track_errs(track_errs), .cmd_rejected(cmd_rejected),
      .unit_check(unit_check), .device_end(device_end),
      .xfer_stop(xfer_stop));
   tss_drive_model drv (.sys_clk(sys_clk), .tape_drive(tape_drive),
                        .evt(evt));

   // 4 ns period
   always #2 sys_clk = ~sys_clk;
   // hang guard: the whole run needs far fewer cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 8000) begin
         fails++;
         final_report();
      end
   end
   // monitor: every accepted read takes the oldest note
   always @(posedge sys_clk)
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && mq.size() > 0)
         chk(wq.pop_front(), vq.pop_front(), avs_readdata & mq.pop_front());

   task automatic chk(input string w, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask
   // short random wait: 0 to 2 cycles
   function automatic int rnd();
      return $unsigned($random(seed)) % 3;
   endfunction
   // avalon read: hold until waitrequest is sampled low
   task automatic rd(input logic [3:0] a, input logic [31:0] m, v,
                     input string w);
      int n;
      n = 0;
      wq.push_back(w);
      mq.push_back(m);
      vq.push_back(v);
      avs_address <= a;
      avs_read <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   // avalon write: registers are read only, so data must be dropped
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 40);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   // one command pulse; e is the expected {reject, unit check}
   task automatic cmd(input logic [7:0] c, input logic [3:0] f,
                      input logic [1:0] e, input string w);
      cmd_code <= c;
      fl <= f;
      cmd_valid <= 1'b1;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(posedge sys_clk);
      chk(w, {30'h0, e}, {30'h0, cmd_rejected, unit_check});
   endtask
   // end the running operation
   task automatic fin();
      drv.fire(16'h0001, rnd());
   endtask
   task automatic final_report();
      fails += mq.size();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      drv.set_drive(drv_rw, 0);
      @(posedge sys_clk);
      wr(`TSS_OFF_SENSE0, $random(seed));
      foreach (addr_t[i])
         rd(addr_t[i], 32'hffffffff, (addr_t[i] == 4'h4) ? 32'h40 : 32'h0,
            "reset value");
      do uc = $random(seed);
      while (uc inside {8'h01, 8'h02, 8'h0c, 8'h04, 8'h1f, 8'h17, 8'h8b,
                        8'h97, 8'hf4, 8'hd4, 8'h03});
      cmd(uc, 4'b0100, 2'b11, "unknown code");
      rd(`TSS_OFF_SENSE0, 32'hc0, 32'h80, "reject only");
      // write-type commands refused without the ring, reads still run
      drv.set_drive(drv_ro, rnd());
      foreach (wcmd_t[i])
         cmd(wcmd_t[i], 4'b0100, 2'b11, "no ring");
      cmd(rdc, 4'b0100, 2'b00, "read no ring");
      fin();
      drv.set_drive(drv_rw, rnd());
      cmd(`TSS_CMD_SEC_ERA, 4'b0110, 2'b11, "erase unchained");
      cmd(`TSS_CMD_SEC_ERA, 4'b1010, 2'b00, "erase chained");
      fin();
      for (int i = 0; i < 6; i++) begin
         cmd(i[0] ? `TSS_CMD_RELEASE : `TSS_CMD_RESERVE, fl_t[i / 2],
             (i < 4) ? 2'b11 : 2'b00, "reserve");
         fin();
      end
      // absent, not ready, ready: selection response and status bits
      for (int i = 0; i < 3; i++) begin
         drv.set_drive(st_t[i], rnd());
         @(posedge sys_clk);
         if (i == 2)
            chk("device end", 32'h1, {31'h0, device_end});
         cmd(rdc, 4'b0100, (i < 2) ? 2'b01 : 2'b00, "select");
         rd(`TSS_OFF_SENSE0, 32'h40, (i < 2) ? 32'h40 : 32'h0,
            "intervention");
         rd(`TSS_OFF_SENSE1, 32'h60, (i == 0) ? 32'h0 :
            (i == 1) ? 32'h20 : 32'h40, "status ab");
         fin();
      end
      // events during an operation, one table case at a time
      foreach (tbl[i]) begin
         md <= tbl[i].md;
         cmd(tbl[i].code, 4'b0100, 2'b00, "accept");
         drv.fire(tbl[i].ev, rnd());
         @(posedge sys_clk);
         chk("stop", {31'h0, tbl[i].ev[14]}, {31'h0, xfer_stop});
         fin();
         rd(tbl[i].a, {24'h0, tbl[i].m}, {24'h0, tbl[i].v}, "sense");
      end
      md <= 3'h0;
      te = $random(seed);
      track_errs <= te;
      cmd(rdc, 4'b0100, 2'b00, "track read");
      fin();
      rd(`TSS_OFF_SENSE2, 32'hff, {24'h0, te}, "track byte");
      drv.set_drive(8'hcc, rnd());
      cmd(rdc, 4'b0100, 2'b00, "seven track");
      fin();
      rd(`TSS_OFF_SENSE2, 32'hff, 32'h03, "seven track");
      // ready lost in mid-motion
      drv.set_drive(drv_rw, rnd());
      cmd(rdc, 4'b0100, 2'b00, "motion");
      drv.set_drive(drv_nr, 0);
      repeat (2) @(posedge sys_clk);
      chk("drop unit check", 32'h1, {31'h0, unit_check});
      rd(`TSS_OFF_SENSE0, 32'h4010, 32'h4010, "reject drive");
      final_report();
   end
endmodule
`default_nettype wire
